/* core/mas_host_port.sv */
// serial host port, conversion timing, end-of-conversion and low-battery logic
// Operation
// RQ1 - external clock select set: conversion timing counts external master clock edges
// RQ2 - external clock select clear: internal clock times conversions, external pin ignored
// RQ3 - low-battery input low sets sticky flag and lights the annunciator (code sets it while low_battery_flag_below is high)
// RQ4 - end-of-conversion output goes low when a fresh result is stored
// RQ5 - serial clock and data are acted on only while select is low
// RQ6 - input bit shifted in on each rising serial clock while selected
// RQ7 - host makes the serial clock; it may idle high or low
// RQ8 - serial output is driven only for a register read request
// RQ9 - serial output changes on falling serial clock edges
// RQ10 - serial output is high impedance while select is high
// RQ11 - one result per 200 ms period; settled after four periods
// RQ12 - end-of-conversion returns high on result read or next conversion start
module mas_host_port
  import mas_pkg::*;
#(
  parameter int unsigned INT_PERIOD = CONV_INT_CYCLES,
  parameter int unsigned EXT_PERIOD = CONV_EXT_TICKS
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ext_clk,
  input wire logic mod_bit,
  input wire logic low_battery_flag_below,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_q,
  output logic dout_oe_n_q,
  output logic eoc_n_q,
  output logic low_battery_flag_seg_on_q
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rst_pipe_q <= 2'h0;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end

  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------
  logic [5:0] bit_cnt_q;
  logic [CMD_BITS-1:0] cmd_sh_q;
  mas_cmd_t cmd_q;
  logic [DATA_BITS-1:0] wdata_q;
  logic [DATA_BITS-1:0] wr_word_q;
  logic [1:0] wr_addr_q;
  logic [1:0] rd_addr_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  mas_regs_t shadow_q;
  logic [DATA_BITS-1:0] rd_word;
  logic in_data;
  logic frame_end;

  function automatic logic [DATA_BITS-1:0] pick_reg(mas_regs_t r, logic [1:0] a);
    logic [DATA_BITS-1:0] w;
    w = '0;
    if (a == ADDR_CTRL)
      w = r.ctrl;
    else if (a == ADDR_STATUS)
      w = r.status;
    else if (a == ADDR_RESULT)
      w = r.result;
    return w;
  endfunction

  assign in_data = (bit_cnt_q > CMD_LAST) && (bit_cnt_q < FRAME_DONE);
  assign frame_end = (bit_cnt_q == FRAME_LAST);
  // shadow is frozen while selected, so this read is quasi-static
  assign rd_word = pick_reg(shadow_q, cmd_q.addr);

  // frame state cleared whenever select is high
  always_ff @(posedge sclk or posedge cs_n) // see RQ5
  begin
    if (cs_n)
    begin
      bit_cnt_q <= 6'h0;
      cmd_sh_q <= '0;
      cmd_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      if (bit_cnt_q != FRAME_DONE)
        bit_cnt_q <= bit_cnt_q + 6'h1; // see RQ6
      if (bit_cnt_q < CMD_LAST)
        cmd_sh_q <= {cmd_sh_q[CMD_BITS-2:0], din}; // see RQ6
      if (bit_cnt_q == CMD_LAST)
        cmd_q <= mas_cmd_t'({cmd_sh_q[CMD_BITS-2:0], din});
      if (in_data)
        wdata_q <= {wdata_q[DATA_BITS-2:0], din}; // see RQ6
    end
  end

  // completion toggles survive deselect; the serial clock is static at reset release
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      wr_word_q <= '0;
      wr_addr_q <= 2'h0;
      rd_addr_q <= 2'h0;
    end
    else if (!cs_n && frame_end) // see RQ5
    begin
      if (cmd_q.read)
      begin
        rd_addr_q <= cmd_q.addr;
        rd_tgl_q <= ~rd_tgl_q;
      end
      else
      begin
        wr_word_q <= {wdata_q[DATA_BITS-2:0], din};
        wr_addr_q <= cmd_q.addr;
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // output launched on falling edges, released at once by select high
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      dout_q <= 1'b0;
      dout_oe_n_q <= 1'b1; // see RQ10
    end
    else if (in_data && cmd_q.read) // see RQ8
    begin
      dout_q <= rd_word[5'(FRAME_LAST - bit_cnt_q)]; // see RQ9
      dout_oe_n_q <= 1'b0;
    end
    else
    begin
      dout_q <= 1'b0;
      dout_oe_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // crossings into the core domain
  // ----------------------------------------------------------------
  logic [5:0] async_in;
  logic [5:0] sync_q;
  logic [5:0] prev_q;
  logic cs_s;
  logic ext_s;
  logic mod_s;
  logic lowbat_s;
  logic ext_rise;
  logic wr_evt;
  logic rd_evt;

  assign async_in = {rd_tgl_q, wr_tgl_q, low_battery_flag_below, mod_bit, ext_clk, cs_n};

  mas_sync #(.WIDTH(6)) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d(async_in),
    .q(sync_q)
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 6'h0;
    else
      prev_q <= sync_q;
  end

  assign cs_s = sync_q[0];
  assign ext_s = sync_q[1];
  assign mod_s = sync_q[2];
  assign lowbat_s = sync_q[3];
  assign ext_rise = ext_s && !prev_q[1];
  assign wr_evt = sync_q[4] ^ prev_q[4];
  assign rd_evt = sync_q[5] ^ prev_q[5];

  // ----------------------------------------------------------------
  // control and conversion timing
  // ----------------------------------------------------------------
  logic ext_sel_q;
  logic ext_sel_d;
  logic tick;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_last;
  logic per_end;
  logic new_result;
  logic restart;
  logic [DATA_BITS-1:0] acc_q;
  logic [DATA_BITS-1:0] result_q;
  logic [2:0] settle_q;

  assign ext_sel_d = (wr_evt && wr_addr_q == ADDR_CTRL) ? wr_word_q[CTRL_EXT_SEL_BIT] : ext_sel_q;
  assign restart = ext_sel_d != ext_sel_q;
  assign tick = ext_sel_q ? ext_rise : 1'b1; // see RQ1, RQ2
  assign per_last = ext_sel_q ? PER_W'(EXT_PERIOD - 1) : PER_W'(INT_PERIOD - 1);
  assign per_end = tick && (per_cnt_q == per_last);
  assign new_result = per_end && !restart; // see RQ11

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_sel_q <= CTRL_EXT_SEL_RST;
    else
      ext_sel_q <= ext_sel_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_cnt_q <= '0;
      acc_q <= '0;
    end
    else if (restart || per_end)
    begin
      per_cnt_q <= '0;
      acc_q <= '0;
    end
    else if (tick)
    begin
      per_cnt_q <= per_cnt_q + PER_W'(1);
      acc_q <= acc_q + DATA_BITS'(mod_s); // see RQ1, RQ2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q <= '0;
      settle_q <= 3'h0;
    end
    else if (restart)
      settle_q <= 3'h0;
    else if (new_result)
    begin
      result_q <= acc_q;
      if (settle_q != SETTLE_PERIODS)
        settle_q <= settle_q + 3'h1; // see RQ11
    end
  end

  // ----------------------------------------------------------------
  // end of conversion, low battery, shadow copy
  // ----------------------------------------------------------------
  logic rd_result;
  logic rd_status;
  logic eoc_start;
  logic low_battery_flag_q;
  mas_regs_t regs_now;

  assign rd_result = rd_evt && rd_addr_q == ADDR_RESULT;
  assign rd_status = rd_evt && rd_addr_q == ADDR_STATUS;
  assign eoc_start = tick && (per_cnt_q == '0);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      eoc_n_q <= 1'b1;
    else if (new_result)
      eoc_n_q <= 1'b0; // see RQ4
    else if (rd_result || eoc_start || restart)
      eoc_n_q <= 1'b1; // see RQ12
  end

  // set wins over the clear by a status read
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_battery_flag_q <= 1'b0;
      low_battery_flag_seg_on_q <= 1'b0;
    end
    else
    begin
      if (lowbat_s)
        low_battery_flag_q <= 1'b1; // see RQ3
      else if (rd_status)
        low_battery_flag_q <= 1'b0;
      low_battery_flag_seg_on_q <= lowbat_s || low_battery_flag_q; // see RQ3
    end
  end

  always_comb
  begin
    regs_now = '0;
    regs_now.ctrl[CTRL_EXT_SEL_BIT] = ext_sel_q;
    regs_now.status[STAT_LOWBAT_BIT] = low_battery_flag_q;
    regs_now.status[STAT_READY_BIT] = !eoc_n_q;
    regs_now.status[STAT_SETTLED_BIT] = settle_q == SETTLE_PERIODS;
    regs_now.status[STAT_EXT_BIT] = ext_sel_q;
    regs_now.result = result_q;
  end

  // refreshed only while deselected
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      shadow_q <= '0;
    else if (cs_s && prev_q[0])
      shadow_q <= regs_now;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_EXT_TICK: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ1
    ext_sel_q && !restart && !(ext_s && !prev_q[1]) |=> per_cnt_q == $past(per_cnt_q))
    else $error("conversion timing moved without an external clock edge");
  AST_INT_TICK: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ2
    !ext_sel_q && !restart && per_cnt_q != per_last |=> per_cnt_q == $past(per_cnt_q) + 1'b1)
    else $error("internal timing did not advance every cycle");
  AST_LOWBAT_SET: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ3
    lowbat_s |=> low_battery_flag_q ##1 low_battery_flag_seg_on_q)
    else $error("low battery not latched or not shown");
  AST_EOC_LOW: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ4
    new_result |=> !eoc_n_q && result_q == $past(acc_q))
    else $error("fresh result without end of conversion low");
  AST_EOC_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ12
    !eoc_n_q && rd_result && !new_result |=> eoc_n_q)
    else $error("end of conversion stayed low after result read");
  AST_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ11
    new_result |=> per_cnt_q == '0 ##1 !new_result)
    else $error("conversion period not restarted");
  AST_HIZ: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ10
    cs_s && prev_q[0] |-> dout_oe_n_q)
    else $error("serial output driven while deselected");
  AST_READ_ONLY: assert property (@(negedge sclk) disable iff (cs_n) // see RQ8
    !dout_oe_n_q |-> cmd_q.read && bit_cnt_q > CMD_LAST)
    else $error("serial output driven outside a read");
  AST_SHIFT: assert property (@(posedge sclk) disable iff (cs_n) // see RQ6
    bit_cnt_q < CMD_LAST |=> cmd_sh_q[0] == $past(din) && bit_cnt_q == $past(bit_cnt_q) + 1'b1)
    else $error("input bit not shifted on rising serial clock");

endmodule // mas_host_port

/* core/mas_pkg.sv */
// shared constants and carrier types for the meter adc serial host port
package mas_pkg;

  // ----------------------------------------------------------------
  // clocks and conversion timing
  // ----------------------------------------------------------------
  localparam longint unsigned CORE_CLK_HZ = 64'd25_000_000;
  localparam longint unsigned EXT_CLK_HZ = 64'd4_915_200;
  localparam longint unsigned CONV_PERIOD_MS = 64'd200;
  localparam longint unsigned CONV_INT_CYCLES_L = CONV_PERIOD_MS * CORE_CLK_HZ / 64'd1000;
  localparam longint unsigned CONV_EXT_TICKS_L = CONV_PERIOD_MS * EXT_CLK_HZ / 64'd1000;
  localparam int unsigned CONV_INT_CYCLES = 32'(CONV_INT_CYCLES_L);
  localparam int unsigned CONV_EXT_TICKS = 32'(CONV_EXT_TICKS_L);
  localparam int PER_W = 23;
  localparam logic [2:0] SETTLE_PERIODS = 3'h4;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 24;
  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] FRAME_DONE = 6'h20;

  // ----------------------------------------------------------------
  // internal register addresses, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_RESULT = 2'h2;
  localparam int CTRL_EXT_SEL_BIT = 0;
  localparam int STAT_LOWBAT_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_SETTLED_BIT = 2;
  localparam int STAT_EXT_BIT = 3;
  localparam logic CTRL_EXT_SEL_RST = 1'b0;

  typedef struct packed {
    logic read;
    logic [4:0] rsvd;
    logic [1:0] addr;
  } mas_cmd_t;

  typedef struct packed {
    logic [DATA_BITS-1:0] ctrl;
    logic [DATA_BITS-1:0] status;
    logic [DATA_BITS-1:0] result;
  } mas_regs_t;

endpackage

/* core/mas_sync.sv */
// two-stage level synchroniser
module mas_sync
  import mas_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // mas_sync

/* dv/mas_host_model.sv */
// serial master model: drives link clock, select and data in
module mas_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_q,
  input wire logic dout_oe_n_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idle_hi;
  logic oe_seen;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b0;
    din = 1'b0;
    idle_hi = 1'b0;
    oe_seen = 1'b0;
    // a clean select rise clears the output stage at start
    #1;
    cs_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // one 32-bit frame; clock runs only inside it
  // ----------------------------------------------------------------
  task automatic frame(input logic sel, input logic [31:0] sh, output logic [23:0] rd);
    rd = 24'h0;
    oe_seen = 1'b0;
    cs_n = ~sel;
    #64;
    for (int i = 31; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = sh[i];
      #16;
      sclk = 1'b1;
      if (dout_oe_n_q === 1'b0)
        oe_seen = 1'b1;
      if (i < 24)
        rd[i] = dout_oe_n_q ? 1'bx : dout_q;
      #16;
    end
    cs_n = 1'b1;
    // released line shows the inverse, not the last bit
    din = ~din;
    sclk = idle_hi;
    #200;
  endtask
endmodule // mas_host_model

/* dv/mas_host_port_tb_top.sv */
// self-checking testbench for the serial host port
module mas_host_port_tb_top import mas_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned IP = 64;
  localparam int unsigned EP = 16;
  logic core_clk, resetn, ext_clk, mod_bit, low_battery_flag_below, sclk, cs_n, din;
  logic dout_q, dout_oe_n_q, eoc_n_q, low_battery_flag_seg_on_q;
  int bad_count, n_tests;

  mas_host_port #(.INT_PERIOD(IP), .EXT_PERIOD(EP)) dut
  (
    .core_clk(core_clk), .resetn(resetn), .ext_clk(ext_clk), .mod_bit(mod_bit),
    .low_battery_flag_below(low_battery_flag_below), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_q(dout_q), .dout_oe_n_q(dout_oe_n_q), .eoc_n_q(eoc_n_q),
    .low_battery_flag_seg_on_q(low_battery_flag_seg_on_q)
  );
  mas_host_model host
  (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout_q(dout_q), .dout_oe_n_q(dout_oe_n_q)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_word({23'h0, got}, {23'h0, exp}, msg);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic wait_lvl(input logic seg, input logic lvl, input int lim, input string msg);
    int n;
    n = 0;
    while (((seg ? low_battery_flag_seg_on_q : eoc_n_q) !== lvl) && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk_bit(seg ? low_battery_flag_seg_on_q : eoc_n_q, lvl, msg);
    if ((seg ? low_battery_flag_seg_on_q : eoc_n_q) !== lvl)
      wrap_up();
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [23:0] v);
    host.frame(1'b1, {1'b1, 5'h0, a, 24'h0}, v);
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [23:0] v);
    logic [23:0] junk;
    host.frame(1'b1, {1'b0, 5'h0, a, v}, junk);
    chk_bit(host.oe_seen, 1'b0, "output driven on write");
  endtask

  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      ext_clk = 1'b1;
      cyc(2);
      ext_clk = 1'b0;
      cyc(2);
    end
  endtask

  always @(dout_q)
    if (dout_oe_n_q === 1'b0 && cs_n === 1'b0)
      chk_bit(sclk, 1'b0, "dout moved off falling edge");

  always @(posedge cs_n)
  begin
    #1;
    chk_bit(dout_oe_n_q, 1'b1, "dout not released");
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [23:0] v;
    chk_bit(eoc_n_q, 1'b1, "eoc after reset");
    chk_bit(low_battery_flag_seg_on_q, 1'b0, "segment after reset");
    rd_reg(ADDR_CTRL, v);
    chk_word(v, 24'h0, "ctrl reset value");
    $display("t_reset done");
  endtask

  task automatic t_internal();
    int n;
    logic [23:0] v;
    wait_lvl(1'b0, 1'b0, 2 * IP + 10, "first result");
    n = 0;
    fork
      ext_pulses(40);
      do
      begin
        cyc(1);
        n++;
      end
      while (eoc_n_q !== 1'b0 && n < 2 * IP);
    join
    chk_word(24'(n), 24'(IP), "internal period ignoring ext clock");
    rd_reg(ADDR_RESULT, v);
    // closing tick of a period is not accumulated
    chk_word(v, 24'(IP - 1), "internal result");
    $display("t_internal done");
  endtask

  task automatic t_external();
    int n;
    logic [23:0] v;
    wr_reg(ADDR_CTRL, 24'h1);
    cyc(2);
    n = 0;
    repeat (IP + 8)
    begin
      cyc(1);
      if (eoc_n_q === 1'b0)
        n++;
    end
    chk_word(24'(n), 24'h0, "result without ext edges");
    ext_pulses(EP - 1);
    chk_bit(eoc_n_q, 1'b1, "result one edge early");
    ext_pulses(1);
    wait_lvl(1'b0, 1'b0, 8, "ext result");
    cyc(20);
    chk_bit(eoc_n_q, 1'b0, "eoc held until read");
    rd_reg(ADDR_STATUS, v);
    chk_word(v, 24'h00000a, "ext status");
    rd_reg(ADDR_RESULT, v);
    chk_word(v, 24'(EP - 1), "ext result");
    wait_lvl(1'b0, 1'b1, 8, "eoc after result read");
    wr_reg(ADDR_CTRL, 24'h0);
    wait_lvl(1'b0, 1'b0, 2 * IP + 10, "back on internal clock");
    $display("t_external done");
  endtask

  task automatic t_low_battery_flag();
    logic [23:0] v;
    low_battery_flag_below = 1'b1;
    wait_lvl(1'b1, 1'b1, 8, "segment on");
    low_battery_flag_below = 1'b0;
    cyc(10);
    chk_bit(low_battery_flag_seg_on_q, 1'b1, "flag sticky");
    rd_reg(ADDR_STATUS, v);
    chk_bit(v[STAT_LOWBAT_BIT], 1'b1, "flag in status");
    wait_lvl(1'b1, 1'b0, 8, "segment off after read");
    rd_reg(ADDR_STATUS, v);
    chk_bit(v[STAT_LOWBAT_BIT], 1'b0, "flag cleared");
    $display("t_low_battery_flag done");
  endtask

  task automatic t_deselected();
    logic [23:0] v;
    host.idle_hi = 1'b1;
    host.frame(1'b0, {8'h00, 24'h1}, v);
    chk_bit(host.oe_seen, 1'b0, "driven while deselected");
    rd_reg(ADDR_CTRL, v);
    chk_word(v, 24'h0, "write while deselected");
    $display("t_deselected done");
  endtask

  // ----------------------------------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    bad_count = 0;
    n_tests = 0;
    resetn = 1'b0;
    ext_clk = 1'b0;
    mod_bit = 1'b1;
    low_battery_flag_below = 1'b0;
    repeat (5) @(posedge core_clk);
    #2;
    resetn = 1'b1;
    cyc(6);
    t_reset();
    t_internal();
    t_external();
    t_low_battery_flag();
    t_deselected();
    wrap_up();
  end

  initial
  begin
    #2ms;
    bad_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    wrap_up();
  end
endmodule // mas_host_port_tb_top
